//--- fssr_sequencer.sv
/*
 Fault shutdown and restart sequencer: fault, start and restart-permit latches.
 Assumes comparator levels from analog sensing; reset stands for power cycling.
*/
`timescale 1ns/10ps
module fssr_sequencer (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // Comparator levels from analog sensing
    input  wire logic i_supply_level_sense,
    input  wire logic i_overvolt_above,
    input  wire logic i_ext_stop_low,
    input  wire logic i_overcurrent_shutdown,
    input  wire logic i_reset_term_low,
    // Pulse-width request from the modulator
    input  wire logic i_pwm_request,
    // Gated outputs
    output logic      o_pwm_out,
    output logic      o_softstart_clamp,
    output logic      o_driver_arm,
    // Status
    output logic      o_fault_latched,
    output logic      o_start_latched,
    output logic      o_restart_permit,
    output logic [fssr_pkg::FSSR_NUM_FAULTS-1:0] o_fault_cause
);
    import fssr_pkg::*;

    logic [4:0] raw_in;
    logic [4:0] sync_in;
    logic       supply_ok;
    logic       low_supply_condition;
    logic       undervolt_fault_gate;
    logic       fault_collect_gate;
    logic       restart_clear_gate;
    logic       softstart_clamp_gate;
    logic [FSSR_NUM_FAULTS-1:0] cause_now;

    logic       fault;
    logic       start;
    logic       permit;
    logic [FSSR_NUM_FAULTS-1:0] cause;
    logic       next_fault;
    logic       next_start;
    logic       next_permit;
    logic [FSSR_NUM_FAULTS-1:0] next_cause;

    assign raw_in = {i_reset_term_low, i_overcurrent_shutdown, i_ext_stop_low,
                     i_overvolt_above, i_supply_level_sense};

    // Comparator synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            fssr_sync u_sync (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_level   (raw_in[gi]),
                .o_level   (sync_in[gi])
            );
        end
    endgenerate

    assign supply_ok            = sync_in[0];
    assign low_supply_condition = !supply_ok;
    // Under-voltage only after a prior start
    assign undervolt_fault_gate = low_supply_condition && start;
    // Over-current is the shutdown comparator only
    assign cause_now = {sync_in[3], sync_in[2], sync_in[1], undervolt_fault_gate};
    assign fault_collect_gate = |cause_now;
    // Clear path from permit latch at low supply
    assign restart_clear_gate = permit && low_supply_condition;
    // Clamp from fault or below start level
    assign softstart_clamp_gate = fault || low_supply_condition;

    always_comb begin
        next_fault  = fault;
        next_start  = start;
        next_permit = permit;
        next_cause  = cause;
        // Start latch sets at start level
        if (supply_ok) begin
            next_start = 1'b1;
        end
        // Fault sticks once seen clear only while supply low
        if (restart_clear_gate) begin
            next_fault = 1'b0;
            next_start = 1'b0;
            next_cause = '0;
        end else if (fault_collect_gate) begin
            next_fault = 1'b1;
            next_cause = cause | cause_now;
        end
        // Permit latch: held clear without fault set by terminal low
        // Holds after a short pulse until the fault latch clears
        if (!fault) begin
            next_permit = 1'b0;
        end else if (sync_in[4]) begin
            next_permit = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault  <= FSSR_FAULT_RST;
            start  <= FSSR_START_RST;
            permit <= FSSR_PERMIT_RST;
            cause  <= '0;
        end else begin
            fault  <= next_fault;
            start  <= next_start;
            permit <= next_permit;
            cause  <= next_cause;
        end
    end

    // Pulse output killed by fault or clamp
    assign o_pwm_out         = i_pwm_request && !softstart_clamp_gate;
    assign o_softstart_clamp = softstart_clamp_gate;
    // Driver-arm follows supply level regardless of fault
    assign o_driver_arm      = supply_ok;
    assign o_fault_latched   = fault;
    assign o_start_latched   = start;
    assign o_restart_permit  = permit;
    assign o_fault_cause     = cause;

    sequence s_fault_set;
        !fault ##1 fault;
    endsequence

    a_fault_kills_pwm: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        fault |-> (!o_pwm_out && o_softstart_clamp))
        else $error("pulse output active while fault set");

    a_low_clamps: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !supply_ok |-> o_softstart_clamp)
        else $error("clamp released below start level");

    a_cause_sets: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (fault_collect_gate && !restart_clear_gate) |=> fault)
        else $error("fault condition not latched");

    a_fault_holds: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (fault && !restart_clear_gate) |=> fault)
        else $error("fault latch dropped without clear");

    a_uv_blocked: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (!start && !supply_ok) |-> !cause_now[FSSR_BIT_UV])
        else $error("undervolt fault before first start");

    a_permit_clear: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !fault |=> !permit)
        else $error("permit set without fault");

    a_permit_follow: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (fault && sync_in[4]) |=> permit)
        else $error("permit did not follow reset terminal");

    a_clear_both: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        restart_clear_gate |=> (!fault && !start))
        else $error("clear did not reset latches");

    a_arm_in_fault: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        s_fault_set ##0 supply_ok |-> (o_driver_arm && !o_pwm_out))
        else $error("driver arm wrong in fault");

    sequence s_permit_pulse;
        (fault && sync_in[4]) ##1 (fault && !sync_in[4]);
    endsequence

    a_permit_holds: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        s_permit_pulse |=> permit)
        else $error("permit dropped after short reset pulse");

    a_start_sets: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        supply_ok |=> start)
        else $error("start latch not set at start level");

    a_refault_after: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        ($fell(restart_clear_gate) && fault_collect_gate) |=> fault)
        else $error("persisting fault not latched again");

    a_arm_cycles: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        fault |-> ((o_driver_arm == supply_ok) && !o_pwm_out))
        else $error("driver arm not following supply in fault");

    a_clamp_release: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (supply_ok && !fault && i_pwm_request) |-> (o_pwm_out && !o_softstart_clamp))
        else $error("clamp held at start level without fault");

    a_oc_cause: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (sync_in[3] && !restart_clear_gate) |=> (fault && cause[FSSR_BIT_OC]))
        else $error("over-current shutdown not recorded");

    a_sync_delay: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(supply_ok) |-> $past(i_supply_level_sense, 2))
        else $error("supply level passed without two-flop delay");
endmodule

//--- fssr_pkg.sv
/*
 Constants shared by the fault shutdown and restart sequencer.
 Assumes all comparator indications arrive as synchronous single-bit levels.
*/
package fssr_pkg;
    // Width of the sticky fault cause vector
    localparam int FSSR_NUM_FAULTS = 4;
    // Fault vector bit positions
    localparam int FSSR_BIT_UV   = 0;
    localparam int FSSR_BIT_OV   = 1;
    localparam int FSSR_BIT_STOP = 2;
    localparam int FSSR_BIT_OC   = 3;
    // Reset values of the latches and the synchroniser stages
    localparam logic FSSR_FAULT_RST   = 1'b0;
    localparam logic FSSR_START_RST   = 1'b0;
    localparam logic FSSR_PERMIT_RST  = 1'b0;
    localparam logic FSSR_SYNC_RST    = 1'b0;
endpackage

//--- fssr_sync.sv
/*
 Two-flop level synchroniser for one comparator output.
 Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module fssr_sync (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // Level in and out
    input  wire logic i_level,
    output logic      o_level
);
    import fssr_pkg::*;

    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    always_comb begin
        next_stage1 = i_level;
        next_stage2 = stage1;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1 <= FSSR_SYNC_RST;
            stage2 <= FSSR_SYNC_RST;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign o_level = stage2;
endmodule

//--- fssr_analog_model.sv
/*
 Model of the supply comparator and the external reset terminal circuitry.
 Assumes the bench commands supply and reset levels; one clock.
*/
`timescale 1ns/10ps
module fssr_analog_model #(
    parameter int RETRY_MAX = 64
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // Commands from the bench
    input  wire logic i_supply_up,
    input  wire logic i_pull_down,
    input  wire logic i_reset_pulse,
    // Driver-arm from the sequencer
    input  wire logic i_driver_arm,
    // Comparator levels
    output logic      o_supply_level_sense,
    output logic      o_reset_term_low
);
    logic       arm_last;
    logic [7:0] retries;
    // Each driver-arm turn-on adds charge to the reset terminal until the count saturates at 255
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            arm_last <= 1'b0;
            retries  <= 8'h00;
        end else begin
            arm_last <= i_driver_arm;
            if (i_driver_arm && !arm_last && retries != 8'hff) begin
                retries <= retries + 8'h01;
            end
        end
    end
    // Momentary pull-down forces the supply comparator low
    assign o_supply_level_sense = i_supply_up && !i_pull_down;
    // Charge past the limit holds the terminal high
    assign o_reset_term_low = i_reset_pulse && (int'(retries) < RETRY_MAX);
endmodule

//--- testbench.sv
/*
 Self-checking bench for the fault shutdown and restart sequencer.
 Assumes the analog model drives supply sense and reset terminal.
*/
`timescale 1ns/10ps
module testbench;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       supply_up = 1'b0;
    logic       pull_down = 1'b0;
    logic       reset_pulse = 1'b0;
    logic       pwm_request = 1'b0;
    logic       overvolt = 1'b0;
    logic       ext_stop = 1'b0;
    logic       overcur = 1'b0;
    logic       sense, term_low, pwm, clamp, arm, fault, start, permit;
    logic [3:0] cause;
    int         miscompares = 0;
    int         samples_checked = 0;

    always #2 sys_clk = ~sys_clk;

    fssr_analog_model i_fssr_analog_model (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
        .i_supply_up(supply_up), .i_pull_down(pull_down), .i_reset_pulse(reset_pulse),
        .i_driver_arm(arm), .o_supply_level_sense(sense), .o_reset_term_low(term_low));

    fssr_sequencer i_fssr_sequencer (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
        .i_supply_level_sense(sense), .i_overvolt_above(overvolt),
        .i_ext_stop_low(ext_stop), .i_overcurrent_shutdown(overcur),
        .i_reset_term_low(term_low), .i_pwm_request(pwm_request), .o_pwm_out(pwm),
        .o_softstart_clamp(clamp), .o_driver_arm(arm), .o_fault_latched(fault),
        .o_start_latched(start), .o_restart_permit(permit), .o_fault_cause(cause));

    task automatic chk(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic give_verdict;
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Pull supply sense low with the terminal low, then let it return
    task automatic restart;
        reset_pulse = 1'b1;
        pull_down = 1'b1;
        wait_n(4);
        chk("fault", fault, 1'b0);
        chk("start", start, 1'b0);
        chk("clamp", clamp, 1'b1);
        pull_down = 1'b0;
        reset_pulse = 1'b0;
        wait_n(4);
    endtask

    initial begin
        wait_n(5);
        reset_n = 1'b1;
        wait_n(4);
        chk("clamp", clamp, 1'b1);
        chk("fault", fault, 1'b0);
        supply_up = 1'b1;
        pwm_request = 1'b1;
        reset_pulse = 1'b1;
        wait_n(4);
        chk("start", start, 1'b1);
        chk("clamp", clamp, 1'b0);
        chk("permit", permit, 1'b0);
        reset_pulse = 1'b0;
        for (int k = 0; k < 4; k++) begin
            case (k)
                0: supply_up = 1'b0;
                1: overvolt = 1'b1;
                2: ext_stop = 1'b1;
                default: overcur = 1'b1;
            endcase
            wait_n(1);
            supply_up = 1'b1;
            {overvolt, ext_stop, overcur} = 3'h0;
            wait_n(4);
            chk("fault", fault, 1'b1);
            chk("cause", cause[k], 1'b1);
            chk("clamp", clamp, 1'b1);
            chk("pwm", pwm, 1'b0);
            chk("arm", arm, 1'b1);
            supply_up = 1'b0;
            wait_n(4);
            chk("fault", fault, 1'b1);
            chk("arm", arm, 1'b0);
            supply_up = 1'b1;
            wait_n(4);
            chk("arm", arm, 1'b1);
            chk("pwm", pwm, 1'b0);
            chk("permit", permit, 1'b0);
            reset_pulse = 1'b1;
            wait_n(1);
            reset_pulse = 1'b0;
            wait_n(2);
            chk("permit", permit, 1'b1);
            wait_n(2);
            chk("permit", permit, 1'b1);
            restart();
            chk("start", start, 1'b1);
            chk("pwm", pwm, 1'b1);
        end
        ext_stop = 1'b1;
        wait_n(4);
        restart();
        chk("fault", fault, 1'b1);
        chk("pwm", pwm, 1'b0);
        give_verdict();
    end

    // Watchdog well beyond the roughly 130 cycles the tests need
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end
endmodule
